/* File: hw/len_decode.v */
/*
  Decodes one programmed length field into a cycle count: the bits above
  LO_W are weighted by MULT, the low bits count one each.
  Assumes MULT and field widths keep the result inside LEN_W bits.
*/
`timescale 1ns/100ps
`include "static_mem_ctrl_consts.vh"

module len_decode #(
  parameter              FIELD_W = 6,
  parameter              LO_W    = 5,
  parameter [`LEN_W-1:0] MULT    = 10'h080
) (
  // programmed field
  input  wire [FIELD_W-1:0] field_i,
  // decoded length in cycles
  output wire [`LEN_W-1:0]  len_o
);

  wire [`LEN_W-1:0] hi_ext;
  wire [`LEN_W-1:0] lo_ext;

  assign hi_ext = {{(`LEN_W-FIELD_W+LO_W){1'b0}}, field_i[FIELD_W-1:LO_W]};
  assign lo_ext = {{(`LEN_W-LO_W){1'b0}}, field_i[LO_W-1:0]};
  assign len_o  = hi_ext * MULT + lo_ext;

endmodule // len_decode

/* File: hw/static_mem_ctrl.v */
/*
  Static memory controller access engine: strobe and chip select
  waveforms, external wait in Frozen and Ready modes, fixed slow-clock
  waveforms and asynchronous page-mode reads.
  Assumes the surrounding register block presents the configuration of the
  requested chip select, stable while req_valid_i is high, and pulses
  other_target_i when the bus serves any other target.
*/
`timescale 1ns/100ps
`include "static_mem_ctrl_consts.vh"

// What this block does
// - Ready mode: count setup and pulse, sample synced wait in last pulse cycle.
// - Ready mode: wait asserted suspends access; after deassertion the hold step runs.
// - Ready mode: wait changes outside the last pulse cycle leave length unchanged.
// - External wait passes a two-cycle resynchronizer before use.
// - Slow clock indication replaces all programmed timings with fixed waveforms.
// - Slow clock waveforms apply to every chip select at once.
// - Slow read: strobe setup 1, pulse 1, cs setup 0, cs pulse 2, cycle 2.
// - Slow write: strobe setup 1, pulse 1, cs setup 0, cs pulse 3, cycle 3.
// - Slow indication removed mid-transfer: finish with slow set at fast rate.
// - Page reads only with page mode enabled; page of 4, 8, 16, 32 bytes.
// - Pages aligned to size; upper address bits form the page address.
// - Page mode: read strobe and chip select low, identical, whole transfer.
// - Page mode: first access uses cs read pulse, in-page uses read strobe pulse.
// - Page mode: read setups and read cycle length have no effect.
// - Page timings applied exactly as programmed, no consistency check.
// - Same chip select and page address: short in-page time, sequential or not.
// - Different page or chip select: page break with long first access.
// - An intervening access to another target forces a page break.
// - Wait mode codes: 00 disabled, 10 Frozen, 11 Ready.
// - Wait is active low, looked at only in the controlling strobe pulse.
// - Entering or leaving slow clock inserts a reload wait after the transfer.
module static_mem_ctrl #(
  parameter NUM_CS = 4,
  parameter CS_W   = 2
) (
  // clock and reset
  input  wire                  mclk_i,
  input  wire                  rst_n_i,
  // access request from the bus side
  input  wire                  req_valid_i,
  input  wire                  req_write_i,
  input  wire [CS_W-1:0]       req_cs_i,
  input  wire [`ADDR_W-1:0]    req_addr_i,
  output wire                  req_ready_o,
  output wire                  xfer_done_o,
  // another internal or external target was accessed
  input  wire                  other_target_i,
  // power management slow clock indication
  input  wire                  slow_clock_i,
  // configuration of the requested chip select
  input  wire [5:0]            rd_strobe_setup_len_i,
  input  wire [5:0]            cs_read_setup_len_i,
  input  wire [5:0]            wr_strobe_setup_len_i,
  input  wire [5:0]            cs_write_setup_len_i,
  input  wire [6:0]            rd_strobe_pulse_len_i,
  input  wire [6:0]            cs_read_pulse_len_i,
  input  wire [6:0]            wr_strobe_pulse_len_i,
  input  wire [6:0]            cs_write_pulse_len_i,
  input  wire [8:0]            read_cycle_len_i,
  input  wire [8:0]            write_cycle_len_i,
  input  wire [1:0]            ext_wait_mode_sel_i,
  input  wire                  page_mode_en_i,
  input  wire [1:0]            page_size_sel_i,
  // external memory pins
  input  wire                  ext_wait_n_i,
  output wire [NUM_CS-1:0]     chip_select_n_o,
  output wire                  read_strobe_n_o,
  output wire                  write_strobe_n_o,
  output wire [`ADDR_W-1:0]    mem_addr_o,
  // status
  output wire                  slow_mode_o,
  output wire                  reload_wait_o
);

  localparam [1:0] ST_IDLE    = 2'h0;
  localparam [1:0] ST_ACCESS  = 2'h1;
  localparam [1:0] ST_SUSPEND = 2'h2;
  localparam [1:0] ST_RELOAD  = 2'h3;

  wire [`LEN_W-1:0]  rd_setup_w;
  wire [`LEN_W-1:0]  cs_rd_setup_w;
  wire [`LEN_W-1:0]  wr_setup_w;
  wire [`LEN_W-1:0]  cs_wr_setup_w;
  wire [`LEN_W-1:0]  rd_pulse_w;
  wire [`LEN_W-1:0]  cs_rd_pulse_w;
  wire [`LEN_W-1:0]  wr_pulse_w;
  wire [`LEN_W-1:0]  cs_wr_pulse_w;
  wire [`LEN_W-1:0]  rd_cycle_w;
  wire [`LEN_W-1:0]  wr_cycle_w;
  wire               wait_n_sync;

  reg  [1:0]         state_reg,     state_next;
  reg  [`LEN_W-1:0]  cnt_reg,       cnt_next;
  reg  [`LEN_W-1:0]  str_setup_reg, str_setup_next;
  reg  [`LEN_W-1:0]  str_pulse_reg, str_pulse_next;
  reg  [`LEN_W-1:0]  cs_setup_reg,  cs_setup_next;
  reg  [`LEN_W-1:0]  cs_pulse_reg,  cs_pulse_next;
  reg  [`LEN_W-1:0]  end_reg,       end_next;
  reg  [1:0]         wmode_reg,     wmode_next;
  reg                is_write_reg,  is_write_next;
  reg  [CS_W-1:0]    cs_sel_reg,    cs_sel_next;
  reg  [`ADDR_W-1:0] addr_reg,      addr_next;
  reg                slow_mode_reg, slow_mode_next;
  reg                page_open_reg, page_open_next;
  reg  [`ADDR_W-1:0] page_addr_reg, page_addr_next;
  reg                rd_n_reg,      rd_n_next;
  reg                wr_n_reg,      wr_n_next;
  reg  [NUM_CS-1:0]  cs_n_reg,      cs_n_next;
  reg                done_reg,      done_next;
  reg                reload_reg,    reload_next;

  reg  [`LEN_W-1:0]  sel_str_setup;
  reg  [`LEN_W-1:0]  sel_str_pulse;
  reg  [`LEN_W-1:0]  sel_cs_setup;
  reg  [`LEN_W-1:0]  sel_cs_pulse;
  reg  [`LEN_W-1:0]  sel_cycle;
  reg  [`LEN_W-1:0]  sel_end;
  reg  [1:0]         sel_wmode;
  reg  [4:0]         page_off_mask;
  reg                page_access;
  reg                page_hit;
  reg                strobe_low;
  reg                cs_low;

  wire [`ADDR_W-1:0] page_keep;
  wire [`LEN_W-1:0]  cnt_inc;
  wire [`LEN_W-1:0]  str_end;
  wire [`LEN_W-1:0]  sel_str_end;
  wire [`LEN_W-1:0]  sel_cs_end;
  wire               in_pulse;
  wire               pulse_last;
  wire               xfer_last;
  wire [NUM_CS-1:0]  cs_onehot;

  // length decoders for the requested chip select
  len_decode #(.FIELD_W(`SETUP_FIELD_W), .LO_W(`SETUP_LO_W), .MULT(`SETUP_HI_MULT)) u_rd_setup (
    .field_i (rd_strobe_setup_len_i),
    .len_o   (rd_setup_w)
  );
  len_decode #(.FIELD_W(`SETUP_FIELD_W), .LO_W(`SETUP_LO_W), .MULT(`SETUP_HI_MULT)) u_cs_rd_setup (
    .field_i (cs_read_setup_len_i),
    .len_o   (cs_rd_setup_w)
  );
  len_decode #(.FIELD_W(`SETUP_FIELD_W), .LO_W(`SETUP_LO_W), .MULT(`SETUP_HI_MULT)) u_wr_setup (
    .field_i (wr_strobe_setup_len_i),
    .len_o   (wr_setup_w)
  );
  len_decode #(.FIELD_W(`SETUP_FIELD_W), .LO_W(`SETUP_LO_W), .MULT(`SETUP_HI_MULT)) u_cs_wr_setup (
    .field_i (cs_write_setup_len_i),
    .len_o   (cs_wr_setup_w)
  );
  len_decode #(.FIELD_W(`PULSE_FIELD_W), .LO_W(`PULSE_LO_W), .MULT(`PULSE_HI_MULT)) u_rd_pulse (
    .field_i (rd_strobe_pulse_len_i),
    .len_o   (rd_pulse_w)
  );
  len_decode #(.FIELD_W(`PULSE_FIELD_W), .LO_W(`PULSE_LO_W), .MULT(`PULSE_HI_MULT)) u_cs_rd_pulse (
    .field_i (cs_read_pulse_len_i),
    .len_o   (cs_rd_pulse_w)
  );
  len_decode #(.FIELD_W(`PULSE_FIELD_W), .LO_W(`PULSE_LO_W), .MULT(`PULSE_HI_MULT)) u_wr_pulse (
    .field_i (wr_strobe_pulse_len_i),
    .len_o   (wr_pulse_w)
  );
  len_decode #(.FIELD_W(`PULSE_FIELD_W), .LO_W(`PULSE_LO_W), .MULT(`PULSE_HI_MULT)) u_cs_wr_pulse (
    .field_i (cs_write_pulse_len_i),
    .len_o   (cs_wr_pulse_w)
  );
  len_decode #(.FIELD_W(`CYCLE_FIELD_W), .LO_W(`CYCLE_LO_W), .MULT(`CYCLE_HI_MULT)) u_rd_cycle (
    .field_i (read_cycle_len_i),
    .len_o   (rd_cycle_w)
  );
  len_decode #(.FIELD_W(`CYCLE_FIELD_W), .LO_W(`CYCLE_LO_W), .MULT(`CYCLE_HI_MULT)) u_wr_cycle (
    .field_i (write_cycle_len_i),
    .len_o   (wr_cycle_w)
  );

  wait_sync u_wait_sync (
    .mclk_i            (mclk_i),
    .rst_n_i           (rst_n_i),
    .ext_wait_n_i      (ext_wait_n_i),
    .ext_wait_n_sync_o (wait_n_sync)
  );

  // page offset bits grow with the page size
  always @* begin
    case (page_size_sel_i)
      `PAGE_SIZE_4:  page_off_mask = 5'h03;
      `PAGE_SIZE_8:  page_off_mask = 5'h07;
      `PAGE_SIZE_16: page_off_mask = 5'h0F;
      `PAGE_SIZE_32: page_off_mask = 5'h1F;
      default:       page_off_mask = 5'h03;
    endcase
  end

  assign page_keep = ~{{(`ADDR_W-5){1'b0}}, page_off_mask};

  // waveform set chosen when a transfer starts
  always @* begin
    page_access = page_mode_en_i && !req_write_i && !slow_mode_reg;
    page_hit    = page_open_reg && (cs_sel_reg == req_cs_i) &&
                  ((req_addr_i & page_keep) == (page_addr_reg & page_keep));
    sel_wmode   = ext_wait_mode_sel_i;
    if (slow_mode_reg) begin
      sel_wmode = `WAIT_MODE_OFF;
      if (req_write_i) begin
        sel_str_setup = `SLOW_WR_SETUP;
        sel_str_pulse = `SLOW_WR_PULSE;
        sel_cs_setup  = `SLOW_CS_WR_SETUP;
        sel_cs_pulse  = `SLOW_CS_WR_PULSE;
        sel_cycle     = `SLOW_WR_CYCLE;
      end else begin
        sel_str_setup = `SLOW_RD_SETUP;
        sel_str_pulse = `SLOW_RD_PULSE;
        sel_cs_setup  = `SLOW_CS_RD_SETUP;
        sel_cs_pulse  = `SLOW_CS_RD_PULSE;
        sel_cycle     = `SLOW_RD_CYCLE;
      end
    end else if (page_access) begin
      sel_str_setup = {`LEN_W{1'b0}};
      sel_cs_setup  = {`LEN_W{1'b0}};
      sel_str_pulse = page_hit ? rd_pulse_w : cs_rd_pulse_w;
      sel_cs_pulse  = sel_str_pulse;
      sel_cycle     = sel_str_pulse;
    end else if (req_write_i) begin
      sel_str_setup = wr_setup_w;
      sel_str_pulse = wr_pulse_w;
      sel_cs_setup  = cs_wr_setup_w;
      sel_cs_pulse  = cs_wr_pulse_w;
      sel_cycle     = wr_cycle_w;
    end else begin
      sel_str_setup = rd_setup_w;
      sel_str_pulse = rd_pulse_w;
      sel_cs_setup  = cs_rd_setup_w;
      sel_cs_pulse  = cs_rd_pulse_w;
      sel_cycle     = rd_cycle_w;
    end
  end

  // transfer ends after the longest of cycle, strobe window and chip select window
  assign sel_str_end = sel_str_setup + sel_str_pulse;
  assign sel_cs_end  = sel_cs_setup + sel_cs_pulse;

  always @* begin
    sel_end = sel_cycle;
    if (sel_str_end > sel_end) begin
      sel_end = sel_str_end;
    end
    if (sel_cs_end > sel_end) begin
      sel_end = sel_cs_end;
    end
  end

  assign cnt_inc    = cnt_reg + 10'h001;
  assign str_end    = str_setup_reg + str_pulse_reg;
  assign in_pulse   = (cnt_reg >= str_setup_reg) && (cnt_reg < str_end);
  assign pulse_last = (str_pulse_reg != {`LEN_W{1'b0}}) && (cnt_inc == str_end);
  assign xfer_last  = (cnt_inc >= end_reg);

  always @* begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    str_setup_next = str_setup_reg;
    str_pulse_next = str_pulse_reg;
    cs_setup_next  = cs_setup_reg;
    cs_pulse_next  = cs_pulse_reg;
    end_next       = end_reg;
    wmode_next     = wmode_reg;
    is_write_next  = is_write_reg;
    cs_sel_next    = cs_sel_reg;
    addr_next      = addr_reg;
    slow_mode_next = slow_mode_reg;
    page_open_next = page_open_reg;
    page_addr_next = page_addr_reg;
    done_next      = 1'b0;
    reload_next    = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (slow_clock_i != slow_mode_reg) begin
          state_next  = ST_RELOAD;
          reload_next = 1'b1;
        end else if (req_valid_i) begin
          state_next     = ST_ACCESS;
          cnt_next       = {`LEN_W{1'b0}};
          str_setup_next = sel_str_setup;
          str_pulse_next = sel_str_pulse;
          cs_setup_next  = sel_cs_setup;
          cs_pulse_next  = sel_cs_pulse;
          end_next       = sel_end;
          wmode_next     = sel_wmode;
          is_write_next  = req_write_i;
          cs_sel_next    = req_cs_i;
          addr_next      = req_addr_i;
          page_open_next = page_access;
          page_addr_next = req_addr_i;
        end
      end
      ST_ACCESS: begin
        if ((wmode_reg == `WAIT_MODE_FROZEN) && in_pulse && !wait_n_sync) begin
          cnt_next = cnt_reg;
        end else if ((wmode_reg == `WAIT_MODE_READY) && pulse_last && !wait_n_sync) begin
          state_next = ST_SUSPEND;
        end else if (xfer_last) begin
          state_next = ST_IDLE;
          cnt_next   = {`LEN_W{1'b0}};
          done_next  = 1'b1;
        end else begin
          cnt_next = cnt_inc;
        end
      end
      ST_SUSPEND: begin
        if (wait_n_sync) begin
          if (xfer_last) begin
            state_next = ST_IDLE;
            cnt_next   = {`LEN_W{1'b0}};
            done_next  = 1'b1;
          end else begin
            state_next = ST_ACCESS;
            cnt_next   = cnt_inc;
          end
        end
      end
      ST_RELOAD: begin
        state_next     = ST_IDLE;
        slow_mode_next = slow_clock_i;
        page_open_next = 1'b0;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (other_target_i) begin
      page_open_next = 1'b0;
    end
  end

  assign cs_onehot = {{(NUM_CS-1){1'b0}}, 1'b1} << cs_sel_next;

  // pin levels from the next counter value so the pins leave flip-flops
  always @* begin
    strobe_low = 1'b0;
    cs_low     = 1'b0;
    if ((state_next == ST_ACCESS) || (state_next == ST_SUSPEND)) begin
      strobe_low = (cnt_next >= str_setup_next) && (cnt_next < str_setup_next + str_pulse_next);
      cs_low     = (cnt_next >= cs_setup_next) && (cnt_next < cs_setup_next + cs_pulse_next);
    end else if (page_open_next) begin
      cs_low = 1'b1;
    end
    rd_n_next = !(strobe_low && !is_write_next);
    wr_n_next = !(strobe_low && is_write_next);
    cs_n_next = cs_low ? ~cs_onehot : {NUM_CS{1'b1}};
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= {`LEN_W{1'b0}};
      str_setup_reg <= {`LEN_W{1'b0}};
      str_pulse_reg <= {`LEN_W{1'b0}};
      cs_setup_reg  <= {`LEN_W{1'b0}};
      cs_pulse_reg  <= {`LEN_W{1'b0}};
      end_reg       <= {`LEN_W{1'b0}};
      wmode_reg     <= `WAIT_MODE_OFF;
      is_write_reg  <= 1'b0;
      cs_sel_reg    <= {CS_W{1'b0}};
      addr_reg      <= {`ADDR_W{1'b0}};
      slow_mode_reg <= 1'b0;
      page_open_reg <= 1'b0;
      page_addr_reg <= {`ADDR_W{1'b0}};
      rd_n_reg      <= 1'b1;
      wr_n_reg      <= 1'b1;
      cs_n_reg      <= {NUM_CS{1'b1}};
      done_reg      <= 1'b0;
      reload_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      str_setup_reg <= str_setup_next;
      str_pulse_reg <= str_pulse_next;
      cs_setup_reg  <= cs_setup_next;
      cs_pulse_reg  <= cs_pulse_next;
      end_reg       <= end_next;
      wmode_reg     <= wmode_next;
      is_write_reg  <= is_write_next;
      cs_sel_reg    <= cs_sel_next;
      addr_reg      <= addr_next;
      slow_mode_reg <= slow_mode_next;
      page_open_reg <= page_open_next;
      page_addr_reg <= page_addr_next;
      rd_n_reg      <= rd_n_next;
      wr_n_reg      <= wr_n_next;
      cs_n_reg      <= cs_n_next;
      done_reg      <= done_next;
      reload_reg    <= reload_next;
    end
  end

  assign req_ready_o      = (state_reg == ST_IDLE) && (slow_clock_i == slow_mode_reg);
  assign xfer_done_o      = done_reg;
  assign chip_select_n_o  = cs_n_reg;
  assign read_strobe_n_o  = rd_n_reg;
  assign write_strobe_n_o = wr_n_reg;
  assign mem_addr_o       = addr_reg;
  assign slow_mode_o      = slow_mode_reg;
  assign reload_wait_o    = reload_reg;

endmodule // static_mem_ctrl

/* File: hw/static_mem_ctrl_consts.vh */
/*
  Shared constants of the static memory controller: wait modes, length
  field layouts, fixed slow-clock waveforms and page size codes.
  Assumes it is included by bare name, before any module that uses it.
*/
`ifndef STATIC_MEM_CTRL_CONSTS_VH
`define STATIC_MEM_CTRL_CONSTS_VH

// widths
`define LEN_W            10
`define ADDR_W           24

// wait mode selector codes
`define WAIT_MODE_OFF    2'h0
`define WAIT_MODE_FROZEN 2'h2
`define WAIT_MODE_READY  2'h3

// length field layouts: len = hi * mult + lo
`define SETUP_FIELD_W    6
`define SETUP_LO_W       5
`define SETUP_HI_MULT    10'h080
`define PULSE_FIELD_W    7
`define PULSE_LO_W       6
`define PULSE_HI_MULT    10'h100
`define CYCLE_FIELD_W    9
`define CYCLE_LO_W       7
`define CYCLE_HI_MULT    10'h100

// fixed slow-clock read waveform, in cycles
`define SLOW_RD_SETUP    10'h001
`define SLOW_RD_PULSE    10'h001
`define SLOW_CS_RD_SETUP 10'h000
`define SLOW_CS_RD_PULSE 10'h002
`define SLOW_RD_CYCLE    10'h002

// fixed slow-clock write waveform, in cycles
`define SLOW_WR_SETUP    10'h001
`define SLOW_WR_PULSE    10'h001
`define SLOW_CS_WR_SETUP 10'h000
`define SLOW_CS_WR_PULSE 10'h003
`define SLOW_WR_CYCLE    10'h003

// page size selector: 4, 8, 16, 32 bytes
`define PAGE_SIZE_4      2'h0
`define PAGE_SIZE_8      2'h1
`define PAGE_SIZE_16     2'h2
`define PAGE_SIZE_32     2'h3

// wait input idle level after reset
`define WAIT_IDLE_LEVEL  1'b1

`endif

/* File: hw/wait_sync.v */
/*
  Two flip-flop resynchronizer for the external active-low wait pin.
  Assumes the pin is asynchronous to mclk_i; idles deasserted after reset.
*/
`timescale 1ns/100ps
`include "static_mem_ctrl_consts.vh"

module wait_sync (
  // clock and reset
  input  wire mclk_i,
  input  wire rst_n_i,
  // raw pin and synchronized level
  input  wire ext_wait_n_i,
  output wire ext_wait_n_sync_o
);

  reg meta_reg;
  reg sync_reg;

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= `WAIT_IDLE_LEVEL;
      sync_reg <= `WAIT_IDLE_LEVEL;
    end else begin
      meta_reg <= ext_wait_n_i;
      sync_reg <= meta_reg;
    end
  end

  assign ext_wait_n_sync_o = sync_reg;

endmodule // wait_sync

/* File: testbench/ext_mem_model.sv */
/* Behavioural external memory that answers each strobe with a wait unless hold_cycles_i is 0.
   Assumes hold_cycles_i is stable while a strobe is low. */
`timescale 1ns/100ps
module ext_mem_model (
  // clock
  input  wire       mclk_i,
  // strobes from the controller
  input  wire       read_strobe_n_i,
  input  wire       write_strobe_n_i,
  // cycles the wait stays asserted, 0 answers at once
  input  wire [3:0] hold_cycles_i,
  // wait pin, pulled up when released
  output wire       ext_wait_n_o
);
  reg  [3:0] busy_cnt_reg = 4'h0;
  reg        wait_n_reg   = 1'b1;
  wire       strobe_on    = !(read_strobe_n_i && write_strobe_n_i);

  // wait held low until the access may complete
  always @(posedge mclk_i) begin
    busy_cnt_reg <= strobe_on ? busy_cnt_reg + 4'h1 : 4'h0;
    wait_n_reg   <= !(strobe_on && busy_cnt_reg < hold_cycles_i);
  end
  assign ext_wait_n_o = wait_n_reg;
endmodule // ext_mem_model

/* File: testbench/static_mem_ctrl_props.sv */
/* Port assertions for the static memory controller.
   Assumes one clock domain; bound onto the design top. */
`timescale 1ns/100ps
module static_mem_ctrl_props #(
  parameter NUM_CS = 4
) (
  input wire              mclk_i,
  input wire              rst_n_i,
  input wire              req_valid_i,
  input wire              req_write_i,
  input wire              req_ready_o,
  input wire              xfer_done_o,
  input wire              slow_clock_i,
  input wire              page_mode_en_i,
  input wire [NUM_CS-1:0] chip_select_n_o,
  input wire              read_strobe_n_o,
  input wire              write_strobe_n_o,
  input wire              slow_mode_o,
  input wire              reload_wait_o
);
  wire take  = req_valid_i && req_ready_o;
  wire cs_on = ~&chip_select_n_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  ready_gate_a: assert property ((slow_clock_i != slow_mode_o) |-> !req_ready_o)
    else $error("ready while waveform set differs");
  busy_after_a: assert property (take |=> !req_ready_o)
    else $error("ready right after a take");
  slow_read_a: assert property (take && slow_mode_o && !req_write_i |=>
    (cs_on && read_strobe_n_o) ##1 (cs_on && !read_strobe_n_o) ##1 (!cs_on && read_strobe_n_o && xfer_done_o))
    else $error("slow read waveform wrong");
  slow_write_a: assert property (take && slow_mode_o && req_write_i |=>
    (cs_on && write_strobe_n_o) ##1 (cs_on && !write_strobe_n_o) ##1 (cs_on && write_strobe_n_o)
    ##1 (!cs_on && xfer_done_o))
    else $error("slow write waveform wrong");
  reload_flip_a: assert property (reload_wait_o |=> $changed(slow_mode_o))
    else $error("reload without mode change");
  mode_switch_a: assert property ($changed(slow_mode_o) |-> $past(reload_wait_o))
    else $error("mode change without reload");
  page_low_a: assert property (take && page_mode_en_i && !req_write_i && !slow_mode_o |=>
    !read_strobe_n_o && cs_on)
    else $error("page read strobes not low at once");
  strobe_excl_a: assert property (!(!read_strobe_n_o && !write_strobe_n_o))
    else $error("both strobes low");

  cover property (take && slow_mode_o && req_write_i);
  cover property (reload_wait_o);
  cover property (take && page_mode_en_i);
endmodule // static_mem_ctrl_props

bind static_mem_ctrl static_mem_ctrl_props #(.NUM_CS(NUM_CS)) props_i (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
  .req_ready_o(req_ready_o), .xfer_done_o(xfer_done_o), .slow_clock_i(slow_clock_i),
  .page_mode_en_i(page_mode_en_i), .chip_select_n_o(chip_select_n_o), .read_strobe_n_o(read_strobe_n_o),
  .write_strobe_n_o(write_strobe_n_o), .slow_mode_o(slow_mode_o), .reload_wait_o(reload_wait_o));

/* File: testbench/tb_static_mem_ctrl.sv */
/* Bench for the static memory controller: wait modes, slow clock
   waveforms and page reads, measured as transfer lengths.
   Assumes the design, checker and memory model are compiled first. */
`timescale 1ns/100ps
module tb_static_mem_ctrl;
  reg         mclk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg         vld = 1'b0, wr = 1'b0, oth = 1'b0, slow = 1'b0, pm = 1'b0;
  reg  [1:0]  cs = 2'h0, wmode = 2'h0, ps = 2'h0;
  reg  [23:0] addr = 24'h000000;
  reg  [5:0]  su_rd = 6'h01, su_csr = 6'h00, su_wr = 6'h01, su_csw = 6'h00;
  reg  [6:0]  pu_rd = 7'h02, pu_csr = 7'h03, pu_wr = 7'h06, pu_csw = 7'h08;
  reg  [8:0]  cy_rd = 9'h004, cy_wr = 9'h008;
  reg  [3:0]  hold = 4'h0;
  wire        ready, done, rd_n, wr_n, wait_n, slow_mode, reload;
  wire [3:0]  cs_n;
  wire [23:0] maddr;
  integer     fail_count = 0;
  integer     num_checks = 0;
  integer     i;

  always #2 mclk_i = ~mclk_i;

  static_mem_ctrl uut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_valid_i(vld), .req_write_i(wr), .req_cs_i(cs),
    .req_addr_i(addr), .req_ready_o(ready), .xfer_done_o(done), .other_target_i(oth), .slow_clock_i(slow),
    .rd_strobe_setup_len_i(su_rd), .cs_read_setup_len_i(su_csr), .wr_strobe_setup_len_i(su_wr),
    .cs_write_setup_len_i(su_csw), .rd_strobe_pulse_len_i(pu_rd), .cs_read_pulse_len_i(pu_csr),
    .wr_strobe_pulse_len_i(pu_wr), .cs_write_pulse_len_i(pu_csw), .read_cycle_len_i(cy_rd),
    .write_cycle_len_i(cy_wr), .ext_wait_mode_sel_i(wmode), .page_mode_en_i(pm), .page_size_sel_i(ps),
    .ext_wait_n_i(wait_n), .chip_select_n_o(cs_n), .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n),
    .mem_addr_o(maddr), .slow_mode_o(slow_mode), .reload_wait_o(reload));
  ext_mem_model mem (.mclk_i(mclk_i), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n),
    .hold_cycles_i(hold), .ext_wait_n_o(wait_n));

  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR %s expected %0d seen %0d", what, exp, seen);
      end
    end
  endtask

  task hang;
    begin
      fail_count = fail_count + 1;
      $display("ERROR handshake expected response seen none");
      print_verdict;
    end
  endtask

  // one request; length counted in cycles from the take to done
  task access(input logic w, input logic [1:0] c, input logic [23:0] a, input logic [31:0] exp);
    integer n;
    begin
      vld = 1'b1;
      wr = w;
      cs = c;
      addr = a;
      n = 0;
      while (ready !== 1'b1) begin
        @(negedge mclk_i);
        n = n + 1;
        if (n > 40) hang;
      end
      @(negedge mclk_i);
      vld = 1'b0;
      check(maddr, a, "address");
      n = 0;
      while (done !== 1'b1) begin
        @(negedge mclk_i);
        n = n + 1;
        if (n > 40) hang;
      end
      check(n, exp, "length");
    end
  endtask

  task set_slow(input logic v);
    integer n, seen;
    begin
      slow = v;
      seen = 0;
      for (n = 0; n < 8; n = n + 1) begin
        @(negedge mclk_i);
        if (reload === 1'b1) seen = seen + 1;
      end
      check(seen, 1, "reload");
      check(slow_mode, v, "slow mode");
    end
  endtask

  task wcase(input logic [1:0] m, input logic [3:0] h, input logic [31:0] exp);
    begin
      wmode = m;
      hold = h;
      access(1'b1, 2'h2, 24'h000040, exp);
    end
  endtask

  initial begin
    repeat (5) @(negedge mclk_i);
    rst_n_i = 1'b1;
    access(1'b0, 2'h0, 24'h000010, 4);
    wcase(2'h0, 4'h5, 8);
    wcase(2'h1, 4'h5, 8);
    wcase(2'h2, 4'h5, 13);
    wcase(2'h3, 4'h5, 11);
    wcase(2'h3, 4'h1, 8);
    $display("wait test done");
    set_slow(1'b1);
    access(1'b0, 2'h3, 24'h000020, 2);
    access(1'b1, 2'h0, 24'h000024, 3);
    fork
      access(1'b1, 2'h1, 24'h000028, 3);
      begin
        repeat (2) @(negedge mclk_i);
        slow = 1'b0;
      end
    join
    set_slow(1'b0);
    $display("slow clock test done");
    wmode = 2'h0; // page reads tested here with wait off
    hold = 4'h0;
    pm = 1'b1;
    ps = 2'h1;
    su_rd = 6'h05;
    su_csr = 6'h05;
    cy_rd = 9'h014;
    pu_csr = 7'h05;
    access(1'b0, 2'h0, 24'h000100, 5);
    access(1'b0, 2'h0, 24'h000107, 2);
    access(1'b0, 2'h0, 24'h000103, 2);
    access(1'b0, 2'h0, 24'h000108, 5);
    access(1'b0, 2'h1, 24'h00010C, 5);
    access(1'b0, 2'h0, 24'h00010C, 5);
    access(1'b0, 2'h0, 24'h000109, 2);
    oth = 1'b1;
    @(negedge mclk_i);
    oth = 1'b0;
    access(1'b0, 2'h0, 24'h000109, 5);
    for (i = 0; i < 4; i = i + 1) begin
      ps = i[1:0];
      access(1'b0, 2'h0, {16'h0002, i[1:0], 6'h00}, 5);
      access(1'b0, 2'h0, {16'h0002, i[1:0], 6'h00} + (24'h000004 << i) - 24'h000001, 2);
      access(1'b0, 2'h0, {16'h0002, i[1:0], 6'h00} + (24'h000004 << i), 5);
    end
    pu_csr = 7'h01;
    pu_rd = 7'h03;
    access(1'b0, 2'h0, 24'h000300, 1);
    access(1'b0, 2'h0, 24'h000301, 3);
    pm = 1'b0;
    access(1'b0, 2'h0, 24'h000300, 20);
    access(1'b0, 2'h0, 24'h000301, 20);
    $display("page mode test done");
    print_verdict;
  end
endmodule // tb_static_mem_ctrl
